// ---- rtl/stpf_pkg.sv ----
// stpf_pkg: constants, register map and carrier types for the port filter
// assumes a 16-port switch with port 0 as the uplink and 4-bit VLAN codes
package stpf_pkg;
  localparam int unsigned NPORT = 16;
  localparam int unsigned PW = 4;
  localparam int unsigned VW = 4;
  localparam int unsigned MACW = 48;
  localparam int unsigned FDEPTH = 8;
  localparam int unsigned CNTW = 4;
  localparam int unsigned ADDRW = 8;
  localparam int unsigned INTW = 3;
  localparam logic [PW-1:0] UPLINK_PORT = 4'h0;
  // register byte offsets
  localparam logic [ADDRW-1:0] OFF_SEND_HOLD = 8'h00;
  localparam logic [ADDRW-1:0] OFF_RECV_HOLD = 8'h04;
  localparam logic [ADDRW-1:0] OFF_NO_LEARN = 8'h08;
  localparam logic [ADDRW-1:0] OFF_DIRECTED = 8'h0c;
  localparam logic [ADDRW-1:0] OFF_FIFO_STAT = 8'h10;
  localparam logic [ADDRW-1:0] OFF_FIFO_LO = 8'h14;
  localparam logic [ADDRW-1:0] OFF_FIFO_HI = 8'h18;
  localparam logic [ADDRW-1:0] OFF_INT_STAT = 8'h1c;
  localparam logic [ADDRW-1:0] OFF_INT_CLR = 8'h20;
  localparam logic [ADDRW-1:0] OFF_INT_EN = 8'h24;
  localparam logic [1:0] TAG_BANK = 2'h1;
  // directed-transmit field layout
  localparam int unsigned DT_ORIG_LSB = 0;
  localparam int unsigned DT_DEST_LSB = 8;
  localparam int unsigned DT_ARM_BIT = 16;
  // fifo status layout
  localparam int unsigned FS_EMPTY_BIT = 8;
  localparam int unsigned FS_FULL_BIT = 9;
  // interrupt bits
  localparam int unsigned INT_CAPT = 0;
  localparam int unsigned INT_SENT = 1;
  localparam int unsigned INT_OVF = 2;
  localparam logic [NPORT-1:0] MASK_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic [PW-1:0] src_port;
    logic [MACW-1:0] src_addr;
    logic [NPORT-1:0] lookup_mask;
    logic nb_hit;
    logic pretag_valid;
    logic [PW-1:0] remote_port;
  } stpf_frame_type;

  typedef struct packed {
    logic valid;
    logic accept;
    logic learn;
    logic directed;
    logic [NPORT-1:0] dest_mask;
    logic vlan_valid;
    logic [VW-1:0] vlan;
  } stpf_route_type;
endpackage

// ---- rtl/stpf_src_fifo.sv ----
// stpf_src_fifo: small fifo holding captured source addresses
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module stpf_src_fifo (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [stpf_pkg::MACW-1:0] push_data,
  input wire logic pop,
  output logic [stpf_pkg::MACW-1:0] head,
  output logic empty,
  output logic full,
  output logic [stpf_pkg::CNTW-1:0] count
);
  logic [stpf_pkg::MACW-1:0] mem_q [stpf_pkg::FDEPTH];
  logic [stpf_pkg::CNTW-2:0] wr_q;
  logic [stpf_pkg::CNTW-2:0] rd_q;
  logic [stpf_pkg::CNTW-1:0] cnt_q;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == stpf_pkg::CNTW'(stpf_pkg::FDEPTH));
  assign count = cnt_q;
  assign head = mem_q[rd_q];

  // storage has no reset; only entries below the count are ever read
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + cnt_one(do_push) - cnt_one(do_pop);
    end
  end

  function automatic logic [stpf_pkg::CNTW-1:0] cnt_one(input logic b);
    cnt_one = {{(stpf_pkg::CNTW-1){1'b0}}, b};
  endfunction
endmodule
`default_nettype wire

// ---- rtl/stpf_port_filter.sv ----
// stpf_port_filter: spanning-tree port filtering, directed transmit,
// non-blocking source capture and remote-port VLAN mapping
// assumes frame requests arrive from the lookup engine on core_clk,
// one valid cycle each, and software uses an AXI4-Lite master
//
// Behaviour
// - learning port: received frames not forwarded
// - learning port: routed frames not sent
// - learning port: source addresses still learned
// - learning: both holds set, no-learn clear
// - blocking: all three mask bits set
// - blocking port: no forward, send, learn
// - forwarding: all three mask bits clear
// - forwarding port: forward, send, learn normally
// - non-blocking hit pushes source into fifo
// - non-blocking hit accepted despite receive hold
// - armed directed transmit overrides lookup, send-hold
// - matching source port goes only to destination
// - directed transmit disarms after one frame
// - uplink pretag mapped to VLAN via tags
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stpf_port_filter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [stpf_pkg::ADDRW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stpf_pkg::ADDRW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire stpf_pkg::stpf_frame_type frame_in,
  output stpf_pkg::stpf_route_type route_out,
  output logic irq
);
  localparam int unsigned NP = stpf_pkg::NPORT;

  function automatic logic [NP-1:0] port_bit(input logic [stpf_pkg::PW-1:0] p);
    port_bit = {{(NP-1){1'b0}}, 1'b1} << p;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // control registers
  logic [NP-1:0] send_hold_mask_q;
  logic [NP-1:0] receive_hold_mask_q;
  logic [NP-1:0] no_learn_mask_q;
  logic [stpf_pkg::PW-1:0] dt_orig_q;
  logic [stpf_pkg::PW-1:0] dt_dest_q;
  logic dt_armed_q;
  logic [stpf_pkg::VW-1:0] remote_port_vlan_tag_q [NP];
  logic [stpf_pkg::INTW-1:0] int_stat_q;
  logic [stpf_pkg::INTW-1:0] int_en_q;
  stpf_pkg::stpf_route_type route_q;

  // write channel decode: address and data taken together
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire [stpf_pkg::ADDRW-1:0] wa = s_axi_awaddr;
  wire [stpf_pkg::ADDRW-1:0] wa_al = {wa[stpf_pkg::ADDRW-1:2], 2'b00};
  wire wa_tag = (wa[7:6] == stpf_pkg::TAG_BANK);
  wire [stpf_pkg::PW-1:0] wa_idx = wa[5:2];
  wire w_send = wr_take && wa_al == stpf_pkg::OFF_SEND_HOLD;
  wire w_recv = wr_take && wa_al == stpf_pkg::OFF_RECV_HOLD;
  wire w_nlrn = wr_take && wa_al == stpf_pkg::OFF_NO_LEARN;
  wire w_dt = wr_take && wa_al == stpf_pkg::OFF_DIRECTED;
  wire w_clr = wr_take && wa_al == stpf_pkg::OFF_INT_CLR;
  wire w_en = wr_take && wa_al == stpf_pkg::OFF_INT_EN;
  wire w_tag = wr_take && wa_tag;
  wire w_ro = wa_al == stpf_pkg::OFF_FIFO_STAT || wa_al == stpf_pkg::OFF_FIFO_LO ||
              wa_al == stpf_pkg::OFF_FIFO_HI || wa_al == stpf_pkg::OFF_INT_STAT;
  wire w_hit = w_send || w_recv || w_nlrn || w_dt || w_clr || w_en || w_tag ||
               (wr_take && w_ro);
  wire [31:0] wd = s_axi_wdata;
  wire [3:0] ws = s_axi_wstrb;

  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= stpf_pkg::RESP_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_hit ? stpf_pkg::RESP_OKAY : stpf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  wire [31:0] send_merged = merge({16'h0000, send_hold_mask_q}, wd, ws);
  wire [31:0] recv_merged = merge({16'h0000, receive_hold_mask_q}, wd, ws);
  wire [31:0] nlrn_merged = merge({16'h0000, no_learn_mask_q}, wd, ws);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      send_hold_mask_q <= stpf_pkg::MASK_RST;
      receive_hold_mask_q <= stpf_pkg::MASK_RST;
      no_learn_mask_q <= stpf_pkg::MASK_RST;
    end else begin
      if (w_send) begin
        send_hold_mask_q <= send_merged[NP-1:0];
      end
      if (w_recv) begin
        receive_hold_mask_q <= recv_merged[NP-1:0];
      end
      if (w_nlrn) begin
        no_learn_mask_q <= nlrn_merged[NP-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NP; i++) begin
        remote_port_vlan_tag_q[i] <= '0;
      end
    end else if (w_tag && ws[0] && wa_idx != stpf_pkg::UPLINK_PORT) begin
      remote_port_vlan_tag_q[wa_idx] <= wd[stpf_pkg::VW-1:0];
    end
  end

  // frame path
  wire stpf_pkg::stpf_frame_type f = frame_in;
  wire [NP-1:0] src_bit = port_bit(f.src_port);
  // source port match on armed register
  wire dt_match = f.valid && dt_armed_q && f.src_port == dt_orig_q;
  wire rx_ok = !(|(receive_hold_mask_q & src_bit)) || f.nb_hit;
  // blocked ports send nothing and receive only non-blocking hits
  wire [NP-1:0] norm_mask = rx_ok ? (f.lookup_mask & ~send_hold_mask_q & ~src_bit) : '0;
  // override of lookup and send hold
  wire [NP-1:0] dest_mask = dt_match ? port_bit(dt_dest_q) : norm_mask;
  wire learn = f.valid && !(|(no_learn_mask_q & src_bit));
  wire tag_ok = f.pretag_valid && f.src_port == stpf_pkg::UPLINK_PORT &&
                f.remote_port != stpf_pkg::UPLINK_PORT;
  wire cap = f.valid && f.nb_hit;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      route_q <= '0;
    end else begin
      route_q.valid <= f.valid;
      route_q.accept <= f.valid && (rx_ok || dt_match);
      route_q.learn <= learn;
      route_q.directed <= dt_match;
      route_q.dest_mask <= f.valid ? dest_mask : '0;
      route_q.vlan_valid <= f.valid && tag_ok;
      // idle cycles may carry stale pretag bits, so the vlan is gated by valid
      route_q.vlan <= (f.valid && tag_ok) ? remote_port_vlan_tag_q[f.remote_port] : '0;
    end
  end
  assign route_out = route_q;

  // self-clearing directed transmit
  // a software arm in the same cycle wins so a new request is not lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dt_orig_q <= '0;
      dt_dest_q <= '0;
      dt_armed_q <= 1'b0;
    end else if (w_dt) begin
      dt_orig_q <= wd[stpf_pkg::DT_ORIG_LSB +: stpf_pkg::PW];
      dt_dest_q <= wd[stpf_pkg::DT_DEST_LSB +: stpf_pkg::PW];
      dt_armed_q <= wd[stpf_pkg::DT_ARM_BIT];
    end else if (dt_match) begin
      dt_armed_q <= 1'b0;
    end
  end

  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire rd_take = s_axi_arvalid && !rvalid_q;
  wire [stpf_pkg::ADDRW-1:0] ra = {s_axi_araddr[stpf_pkg::ADDRW-1:2], 2'b00};
  wire ra_tag = (s_axi_araddr[7:6] == stpf_pkg::TAG_BANK);
  wire [stpf_pkg::PW-1:0] ra_idx = s_axi_araddr[5:2];

  logic [stpf_pkg::MACW-1:0] fifo_head;
  logic fifo_empty;
  logic fifo_full;
  logic [stpf_pkg::CNTW-1:0] fifo_count;
  // a low-word read pops, so read the high word first
  wire fifo_pop = rd_take && ra == stpf_pkg::OFF_FIFO_LO;

  stpf_src_fifo u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .push(cap),
    .push_data(f.src_addr),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full),
    .count(fifo_count)
  );

  wire [31:0] fifo_stat = {22'h000000, fifo_full, fifo_empty, 4'h0, fifo_count};
  wire [31:0] dt_word = {15'h0000, dt_armed_q, 4'h0, dt_dest_q, 4'h0, dt_orig_q};
  wire [31:0] tag_word = {28'h0000000,
                          ra_idx == stpf_pkg::UPLINK_PORT ? 4'h0 : remote_port_vlan_tag_q[ra_idx]};
  wire r_hit = ra_tag || ra == stpf_pkg::OFF_SEND_HOLD || ra == stpf_pkg::OFF_RECV_HOLD ||
               ra == stpf_pkg::OFF_NO_LEARN || ra == stpf_pkg::OFF_DIRECTED ||
               ra == stpf_pkg::OFF_FIFO_STAT || ra == stpf_pkg::OFF_FIFO_LO ||
               ra == stpf_pkg::OFF_FIFO_HI || ra == stpf_pkg::OFF_INT_STAT ||
               ra == stpf_pkg::OFF_INT_CLR || ra == stpf_pkg::OFF_INT_EN;
  wire [31:0] rd_mux =
    ra_tag ? tag_word :
    ra == stpf_pkg::OFF_SEND_HOLD ? {16'h0000, send_hold_mask_q} :
    ra == stpf_pkg::OFF_RECV_HOLD ? {16'h0000, receive_hold_mask_q} :
    ra == stpf_pkg::OFF_NO_LEARN ? {16'h0000, no_learn_mask_q} :
    ra == stpf_pkg::OFF_DIRECTED ? dt_word :
    ra == stpf_pkg::OFF_FIFO_STAT ? fifo_stat :
    ra == stpf_pkg::OFF_FIFO_LO ? (fifo_empty ? 32'h00000000 : fifo_head[31:0]) :
    ra == stpf_pkg::OFF_FIFO_HI ? (fifo_empty ? 32'h00000000 : {16'h0000, fifo_head[47:32]}) :
    ra == stpf_pkg::OFF_INT_STAT ? {29'h00000000, int_stat_q} :
    ra == stpf_pkg::OFF_INT_EN ? {29'h00000000, int_en_q} : 32'h00000000;

  assign s_axi_arready = rd_take;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= stpf_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= r_hit ? stpf_pkg::RESP_OKAY : stpf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  wire [stpf_pkg::INTW-1:0] ev;
  assign ev[stpf_pkg::INT_CAPT] = cap && !fifo_full;
  assign ev[stpf_pkg::INT_SENT] = dt_match;
  assign ev[stpf_pkg::INT_OVF] = cap && fifo_full;
  wire [stpf_pkg::INTW-1:0] clr = w_clr && ws[0] ? wd[stpf_pkg::INTW-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_stat_q <= '0;
      int_en_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~clr) | ev;
      if (w_en && ws[0]) begin
        int_en_q <= wd[stpf_pkg::INTW-1:0];
      end
    end
  end

  assign irq = |(int_stat_q & int_en_q);
endmodule
`default_nettype wire

// ---- tb/stpf_port_filter_asserts.sv ----
// stpf_port_filter_asserts: route-path checks on the frame ports
// assumes it is bound into stpf_port_filter, one clock domain
`timescale 1ns/1ps
`default_nettype none
module stpf_port_filter_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire stpf_pkg::stpf_frame_type frame_in,
  input wire stpf_pkg::stpf_route_type route_out
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_lat;
    route_out.valid == $past(frame_in.valid);
  endproperty
  a_lat: assert property (p_lat)
    else $error("route valid not one cycle after frame");
  property p_no_self;
    route_out.valid && !route_out.directed |-> !route_out.dest_mask[$past(frame_in.src_port)];
  endproperty
  a_no_self: assert property (p_no_self)
    else $error("frame sent back to its own port");
  property p_subset;
    route_out.valid && !route_out.directed
      |-> (route_out.dest_mask & ~$past(frame_in.lookup_mask)) == '0;
  endproperty
  a_subset: assert property (p_subset)
    else $error("destination outside lookup result");
  property p_held;
    route_out.valid && !route_out.accept |-> route_out.dest_mask == '0;
  endproperty
  a_held: assert property (p_held)
    else $error("refused frame still routed");
  property p_nb;
    $past(frame_in.valid && frame_in.nb_hit) |-> route_out.accept;
  endproperty
  a_nb: assert property (p_nb)
    else $error("non-blocking hit not accepted");
  property p_dir;
    route_out.directed |-> route_out.valid && route_out.accept && $onehot(route_out.dest_mask);
  endproperty
  a_dir: assert property (p_dir)
    else $error("directed frame not to a single port");
  property p_idle;
    !route_out.valid |-> route_out == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("route fields set without valid");
  property p_vlan;
    route_out.vlan_valid |-> $past(frame_in.pretag_valid && frame_in.src_port == 4'h0
      && frame_in.remote_port != 4'h0);
  endproperty
  a_vlan: assert property (p_vlan)
    else $error("vlan given without uplink pretag");
  property p_learn;
    route_out.learn |-> route_out.valid;
  endproperty
  a_learn: assert property (p_learn)
    else $error("learn without a frame");
  c_dir: cover property (route_out.directed);
  c_nb: cover property ($past(frame_in.nb_hit && frame_in.valid) && route_out.accept);
  c_vlan: cover property (route_out.vlan_valid);
endmodule
bind stpf_port_filter stpf_port_filter_asserts stpf_port_filter_asserts_i (
  .core_clk(core_clk), .rst_n(rst_n), .frame_in(frame_in), .route_out(route_out));
`default_nettype wire

// ---- tb/stpf_lookup_model.sv ----
// stpf_lookup_model: lookup engine side, hands one frame per send pulse
// assumes send is a one-cycle request on core_clk
`timescale 1ns/1ps
`default_nettype none
module stpf_lookup_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic send,
  input wire stpf_pkg::stpf_frame_type req,
  output stpf_pkg::stpf_frame_type frame_in
);
  localparam int FW = $bits(stpf_pkg::stpf_frame_type);
  // entry valid flag forced set on send
  // idle fields toggle so a stale value is never mistaken for data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frame_in <= '0;
    end else if (send) begin
      frame_in <= {1'b1, req[FW-2:0]};
    end else begin
      frame_in <= {1'b0, ~frame_in[FW-2:0]};
    end
  end
endmodule
`default_nettype wire

// ---- tb/stpf_port_filter_tb.sv ----
// stpf_port_filter_tb: register, filter, capture and directed-send tests
// assumes the design answers per the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module stpf_port_filter_tb;
  logic core_clk, rst_n, awv, wv, bry, arv, rry, snd, irq;
  logic awr, wrd, bv, arr, rv;
  logic [7:0] aa, ra;
  logic [31:0] wd, rd_d, v;
  logic [1:0] br, rr, rsp;
  stpf_pkg::stpf_frame_type fq, fin;
  stpf_pkg::stpf_route_type ro, got;
  int n_errors = 0;
  int compares = 0;
  stpf_port_filter stpf_port_filter_i (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .frame_in(fin), .route_out(ro), .irq(irq));
  stpf_lookup_model stpf_lookup_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .send(snd), .req(fq), .frame_in(fin));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rt(input logic [2:0] ald, input logic [15:0] dm);
    compares++;
    if ({got.accept, got.learn, got.directed, got.dest_mask} !== {ald, dm}) begin
      n_errors++;
      $display("mismatch t=%0t route %b %h", $time, got.dest_mask, got.accept);
    end
  endtask
  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    chk(32'(irq), 32'(e));
    @(posedge core_clk);
  endtask
  // samples at the falling edge; the value holds until the next rising edge
  task automatic wt(input int k);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (!s) begin
      @(negedge core_clk);
      s = ((k == 0 ? awr : k == 1 ? bv : k == 2 ? arr : rv) === 1'b1);
      n++;
      if (n > 100) begin
        n_errors++;
        $display("mismatch t=%0t wait timed out", $time);
        tally_and_finish();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    wt(0);
    @(posedge core_clk);
    awv <= 1'b0;
    wv <= 1'b0;
    bry <= 1'b1;
    wt(1);
    rsp = br;
    @(posedge core_clk);
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    ra <= a;
    arv <= 1'b1;
    wt(2);
    @(posedge core_clk);
    arv <= 1'b0;
    rry <= 1'b1;
    wt(3);
    v = rd_d;
    rsp = rr;
    @(posedge core_clk);
    rry <= 1'b0;
  endtask
  task automatic fr(input logic [3:0] p, input logic [15:0] m, input logic nb,
                    input logic [3:0] rp);
    fq <= '{valid: 1'b0, src_port: p, src_addr: 48'h0123_4567_89ab, lookup_mask: m,
      nb_hit: nb, pretag_valid: (rp != 4'h0), remote_port: rp};
    snd <= 1'b1;
    @(posedge core_clk);
    snd <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    got = ro;
    @(posedge core_clk);
  endtask
  task automatic t_reset;
    rd(8'h00);
    chk(v, 32'h0);
    rd(8'h10);
    chk(v, 32'h100);
    rd(8'h3c);
    chk(32'(rsp), 32'h2);
    wr(8'h3c, 32'h0);
    chk(32'(rsp), 32'h2);
    wr(8'h00, 32'h0);
    chk(32'(rsp), 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_states;
    wr(8'h00, 32'h28);
    wr(8'h04, 32'h28);
    wr(8'h08, 32'h20);
    fr(4'h3, 16'hffff, 1'b0, 4'h0);
    chk_rt(3'b010, 16'h0);
    fr(4'h5, 16'hffff, 1'b0, 4'h0);
    chk_rt(3'b000, 16'h0);
    fr(4'h1, 16'hffff, 1'b0, 4'h0);
    chk_rt(3'b110, 16'hffd5);
    $display("t_states done");
  endtask
  task automatic t_nb;
    wr(8'h24, 32'h1);
    fr(4'h5, 16'h0002, 1'b1, 4'h0);
    chk_rt(3'b100, 16'h0002);
    chk_irq(1'b1);
    rd(8'h10);
    chk(v, 32'h1);
    rd(8'h18);
    chk(v, 32'h0123);
    rd(8'h14);
    chk(v, 32'h456789ab);
    rd(8'h1c);
    chk(v, 32'h1);
    wr(8'h24, 32'h0);
    chk_irq(1'b0);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h1);
    chk_irq(1'b0);
    rd(8'h10);
    chk(v, 32'h100);
    repeat (9) fr(4'h1, 16'h0000, 1'b1, 4'h0);
    rd(8'h10);
    chk(v, 32'h208);
    rd(8'h1c);
    chk(v, 32'h5);
    $display("t_nb done");
  endtask
  task automatic t_dir;
    wr(8'h0c, 32'h0001_0502);
    fr(4'h2, 16'h0001, 1'b0, 4'h0);
    chk_rt(3'b111, 16'h0020);
    rd(8'h0c);
    chk(v, 32'h0502);
    rd(8'h1c);
    chk(v, 32'h7);
    fr(4'h2, 16'h0001, 1'b0, 4'h0);
    chk_rt(3'b110, 16'h0001);
    $display("t_dir done");
  endtask
  task automatic t_vlan;
    wr(8'h5c, 32'ha);
    rd(8'h5c);
    chk(v, 32'ha);
    wr(8'h40, 32'hf);
    rd(8'h40);
    chk(v, 32'h0);
    fr(4'h0, 16'h0, 1'b0, 4'h7);
    chk(32'({got.vlan_valid, got.vlan}), 32'h1a);
    fr(4'h0, 16'h0, 1'b0, 4'h0);
    chk(32'(got.vlan_valid), 32'h0);
    $display("t_vlan done");
  endtask
  initial begin
    rst_n = 1'b0;
    {awv, wv, bry, arv, rry, snd} = '0;
    {aa, ra, wd} = '0;
    fq = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_states();
    t_nb();
    t_dir();
    t_vlan();
    tally_and_finish();
  end
endmodule
`default_nettype wire
